// ==== verilog/dsfm_pkg.sv ====
// Constants, register map and states for the DS3 receive frame maintenance.
// Assumes a classic Wishbone slave with 8-bit data, byte-indexed offsets.
package dsfm_pkg;
    localparam logic [7:0] ADDR_IO_CTRL = 8'h01;
    localparam logic [7:0] ADDR_RX_CFG = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h20;
    localparam logic [7:0] ADDR_INT_MASK = 8'h21;
    localparam logic [7:0] IO_CTRL_RESET = 8'ha0;
    localparam int IO_REFRAME_BIT = 0;
    localparam int CFG_MSYNC_BIT = 0;
    localparam int CFG_FSYNC_BIT = 1;
    localparam int CFG_PARITY_BIT = 2;
    localparam int CFG_OOF_BIT = 4;
    localparam int CFG_RW_BITS = 4;
    // Frame geometry: 7 subframes of 8 blocks of 85 bits
    localparam int BLK_BITS = 85;
    localparam int BLKS_PER_SUB = 8;
    localparam int SUBS_PER_MF = 7;
    localparam logic [3:0] F_PATTERN = 4'h9;
    localparam logic [2:0] M_PATTERN = 3'h2;
    localparam int F_WIN = 16;
    localparam int F_LIMIT_SLOW = 6;
    localparam int F_LIMIT_FAST = 3;
    localparam int M_WIN = 4;
    localparam int M_LIMIT = 3;
    localparam int P_WIN = 5;
    localparam int P_LIMIT = 2;
    localparam int F_GOOD_NEED = 10;
    localparam int M_GOOD_NEED = 3;
    typedef enum logic [1:0] {DSFM_F_SEARCH, DSFM_M_SEARCH,
        DSFM_IN_FRAME} dsfm_state_t;
endpackage

// ==== verilog/dsfm_window.sv ====
// Sliding error window: counts errors among the last WIN flagged bits.
// Assumes one-cycle strobes in the system clock domain.
`timescale 1ns/10ps
module dsfm_window #(
    parameter int WIN = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic strobe_i,
    input wire logic err_i,
    output logic [4:0] count_o
);
    logic [WIN-1:0] hist;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hist <= '0;
        end else if (clear_i) begin
            hist <= '0;
        end else if (strobe_i) begin
            hist <= {hist[WIN-2:0], err_i};
        end
    end
    always_comb begin
        count_o = 5'h00;
        for (int i = 0; i < WIN; i++) begin
            count_o = count_o + {4'h0, hist[i]};
        end
    end
endmodule // dsfm_window

// ==== verilog/dsfm_top.sv ====
// Receive frame alignment and maintenance with a Wishbone register slave.
// Assumes line clock and data are asynchronous pins from the line unit.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module dsfm_top #(
    parameter int BLK_BITS = dsfm_pkg::BLK_BITS
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [7:0] DAT_I,
    input wire logic SEL_I,
    output logic [7:0] DAT_O,
    output logic ACK_O,
    input wire logic RX_LINE_CLK_I,
    input wire logic RX_DATA_I,
    output logic LOSS_OF_ALIGNMENT_O,
    output logic INT_O
);
    // Two-flop synchronisers for the pins
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    logic bit_stb;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], RX_LINE_CLK_I};
            dat_sync <= {dat_sync[0], RX_DATA_I};
            clk_prev <= clk_sync[1];
        end
    end
    assign bit_stb = clk_sync[1] & ~clk_prev;
    wire logic rx_bit = dat_sync[1];

    // Registers
    logic [7:0] io_ctrl;
    logic [3:0] cfg;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic reframe_req;
    logic loss_of_alignment;
    dsfm_pkg::dsfm_state_t state;
    wire logic bus_req = CYC_I & STB_I & ~ACK_O;
    wire logic wr = bus_req & WE_I & SEL_I;
    wire logic rd_stat = bus_req & ~WE_I & (ADR_I == dsfm_pkg::ADDR_INT_STAT);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= bus_req;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            io_ctrl <= dsfm_pkg::IO_CTRL_RESET;
            cfg <= 4'h0;
            int_mask <= 2'h0;
            reframe_req <= 1'b0;
        end else begin
            reframe_req <= 1'b0;
            if (wr && ADR_I == dsfm_pkg::ADDR_IO_CTRL) begin
                // Reframe bit self-clears; one trigger per write
                io_ctrl <= {DAT_I[7:1], 1'b0};
                reframe_req <= DAT_I[dsfm_pkg::IO_REFRAME_BIT];
            end
            if (wr && ADR_I == dsfm_pkg::ADDR_RX_CFG) begin
                cfg <= DAT_I[dsfm_pkg::CFG_RW_BITS-1:0];
            end
            if (wr && ADR_I == dsfm_pkg::ADDR_INT_MASK) begin
                int_mask <= DAT_I[1:0];
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            DAT_O <= 8'h00;
        end else begin
            DAT_O <= 8'h00;
            if (bus_req && !WE_I) begin
                unique case (ADR_I)
                    dsfm_pkg::ADDR_IO_CTRL: DAT_O <= io_ctrl;
                    dsfm_pkg::ADDR_RX_CFG: DAT_O <= {3'h0, loss_of_alignment, cfg};
                    dsfm_pkg::ADDR_INT_STAT: DAT_O <= {6'h00, int_stat};
                    dsfm_pkg::ADDR_INT_MASK: DAT_O <= {6'h00, int_mask};
                    default: DAT_O <= 8'h00;
                endcase
            end
        end
    end

    // Frame position: bit in block, block in subframe, subframe in multiframe
    logic [6:0] bit_pos;
    logic [2:0] blk_pos;
    logic [2:0] sub_pos;
    logic slip;
    wire logic oh_bit = bit_stb && bit_pos == 7'h00;
    // F-bits sit at odd blocks (1,3,5,7); M at block 0 of subframes 4..6
    wire logic is_f = oh_bit && blk_pos[0];
    wire logic is_m = oh_bit && blk_pos == 3'h0 && sub_pos >= 3'h4;
    wire logic is_p = oh_bit && blk_pos == 3'h0 && sub_pos == 3'h2;
    wire logic [1:0] f_idx = blk_pos[2:1];
    wire logic [1:0] m_idx = 2'(sub_pos - 3'h4);
    wire logic f_err = rx_bit != dsfm_pkg::F_PATTERN[3 - f_idx];
    wire logic m_err = rx_bit != dsfm_pkg::M_PATTERN[2 - m_idx];
    wire logic mf_end = oh_bit && blk_pos == 3'h7 && sub_pos == 3'h6;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bit_pos <= 7'h00;
            blk_pos <= 3'h0;
            sub_pos <= 3'h0;
        end else if (bit_stb && !slip) begin
            if (bit_pos == 7'(BLK_BITS - 1)) begin
                bit_pos <= 7'h00;
                blk_pos <= blk_pos + 3'h1;
                if (blk_pos == 3'(dsfm_pkg::BLKS_PER_SUB - 1)) begin
                    sub_pos <= (sub_pos == 3'(dsfm_pkg::SUBS_PER_MF - 1))
                        ? 3'h0 : sub_pos + 3'h1;
                end
            end else begin
                bit_pos <= bit_pos + 7'h01;
            end
        end
    end

    // Parity: P-bit compared to payload parity of previous multiframe
    logic par_acc;
    logic par_prev;
    logic p_err_mf;
    logic p_seen;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            par_acc <= 1'b0;
            par_prev <= 1'b0;
            p_err_mf <= 1'b0;
        end else if (bit_stb) begin
            if (mf_end) begin
                par_prev <= par_acc;
                par_acc <= 1'b0;
                p_err_mf <= 1'b0;
            end else if (is_p) begin
                p_err_mf <= rx_bit != par_prev;
            end else if (bit_pos != 7'h00) begin
                par_acc <= par_acc ^ rx_bit;
            end
        end
    end
    assign p_seen = mf_end;

    // Error windows
    logic [4:0] f_cnt;
    logic [4:0] m_cnt;
    logic [4:0] p_cnt;
    wire logic in_frame = state == dsfm_pkg::DSFM_IN_FRAME;
    dsfm_window #(.WIN(dsfm_pkg::F_WIN)) u_fwin (.clk_i(CLK_I),
        .rst_i(SYS_RST_I), .clear_i(!in_frame), .strobe_i(is_f),
        .err_i(f_err), .count_o(f_cnt));
    dsfm_window #(.WIN(dsfm_pkg::M_WIN)) u_mwin (.clk_i(CLK_I),
        .rst_i(SYS_RST_I), .clear_i(!in_frame), .strobe_i(is_m),
        .err_i(m_err), .count_o(m_cnt));
    dsfm_window #(.WIN(dsfm_pkg::P_WIN)) u_pwin (.clk_i(CLK_I),
        .rst_i(SYS_RST_I), .clear_i(!in_frame), .strobe_i(p_seen),
        .err_i(p_err_mf), .count_o(p_cnt));

    wire logic [4:0] f_lim = cfg[dsfm_pkg::CFG_FSYNC_BIT]
        ? 5'(dsfm_pkg::F_LIMIT_FAST) : 5'(dsfm_pkg::F_LIMIT_SLOW);
    logic lose;
    always_comb begin
        lose = 1'b0;
        if (in_frame) begin
            if (f_cnt >= f_lim) lose = 1'b1;
            // M errors only count when enabled
            if (cfg[dsfm_pkg::CFG_MSYNC_BIT] &&
                m_cnt >= 5'(dsfm_pkg::M_LIMIT)) lose = 1'b1;
            if (cfg[dsfm_pkg::CFG_PARITY_BIT] &&
                p_cnt >= 5'(dsfm_pkg::P_LIMIT)) lose = 1'b1;
        end
    end

    // Acquisition and maintenance state machine
    logic [3:0] good_cnt;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state <= dsfm_pkg::DSFM_F_SEARCH;
            good_cnt <= 4'h0;
            slip <= 1'b0;
        end else begin
            slip <= 1'b0;
            if (reframe_req || lose) begin
                state <= dsfm_pkg::DSFM_F_SEARCH;
                good_cnt <= 4'h0;
            end else begin
                unique case (state)
                    dsfm_pkg::DSFM_F_SEARCH: begin
                        if (is_f && f_err) begin
                            good_cnt <= 4'h0;
                            slip <= 1'b1;
                        end else if (is_f) begin
                            if (good_cnt == 4'(dsfm_pkg::F_GOOD_NEED - 1)) begin
                                state <= dsfm_pkg::DSFM_M_SEARCH;
                                good_cnt <= 4'h0;
                            end else begin
                                good_cnt <= good_cnt + 4'h1;
                            end
                        end
                    end
                    dsfm_pkg::DSFM_M_SEARCH: begin
                        if ((is_m && m_err) || (is_f && f_err)) begin
                            state <= dsfm_pkg::DSFM_F_SEARCH;
                            good_cnt <= 4'h0;
                        end else if (mf_end) begin
                            if (good_cnt == 4'(dsfm_pkg::M_GOOD_NEED - 1)) begin
                                state <= dsfm_pkg::DSFM_IN_FRAME;
                            end else begin
                                good_cnt <= good_cnt + 4'h1;
                            end
                        end
                    end
                    dsfm_pkg::DSFM_IN_FRAME: good_cnt <= 4'h0;
                endcase
            end
        end
    end

    // Out-of-frame flag and pin follow the state
    wire logic next_oof = state != dsfm_pkg::DSFM_IN_FRAME;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            loss_of_alignment <= 1'b1;
        end else begin
            loss_of_alignment <= next_oof;
        end
    end
    assign LOSS_OF_ALIGNMENT_O = loss_of_alignment;

    // Interrupt status: bit0 oof change or forced reframe, bit1 forced reframe; read clears
    wire logic oof_chg = loss_of_alignment != next_oof;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            int_stat <= 2'h0;
        end else begin
            int_stat[0] <= oof_chg | reframe_req |
                (int_stat[0] & ~rd_stat);
            int_stat[1] <= reframe_req | (int_stat[1] & ~rd_stat);
        end
    end
    assign INT_O = |(int_stat & int_mask);

    a_lose_to_search: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) lose |=> state == dsfm_pkg::DSFM_F_SEARCH)
        else $error("Loss did not restart search");
    a_oof_pin_high: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (lose || reframe_req) |=> ##1 loss_of_alignment)
        else $error("Out-of-frame pin not raised");
    a_oof_int_set: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) oof_chg |=> int_stat[0])
        else $error("Change interrupt not set");
    a_msync_off: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (in_frame && f_cnt < f_lim && !cfg[0]
        && !cfg[2]) |-> !lose)
        else $error("M errors caused loss while disabled");
    a_fast_limit: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (in_frame && cfg[1] && f_cnt >= 5'h03)
        |=> !in_frame)
        else $error("Three F errors ignored");
    a_slow_limit: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (in_frame && f_cnt >= 5'h06) |=> !in_frame)
        else $error("Six F errors ignored");
    a_mbit_limit: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (in_frame && cfg[0] && m_cnt >= 5'h03)
        |=> !in_frame)
        else $error("M errors ignored");
    a_reframe_once: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) reframe_req |=> !reframe_req)
        else $error("Reframe held longer than one cycle");
endmodule // dsfm_top

// ==== test/dsfm_line_model.sv ====
// Line unit model: free-running recovered clock and framed line data.
// Assumes dsfm_pkg; the bench corrupts F- or M-bits via f_bad, m_bad.
`timescale 1ns/10ps
module dsfm_line_model #(
    parameter int BLK = dsfm_pkg::BLK_BITS
) (
    output logic line_clk_o,
    output logic data_o
);
    int pos = 0;
    int f_bad = 0;
    int m_bad = 0;
    int p_bad = 0;
    int blk;
    int sub;
    logic bit_v;
    initial line_clk_o = 1'b0;
    initial data_o = 1'b0;
    always #62.5 line_clk_o = ~line_clk_o;
    // Data changes on the falling edge, stable around the rising edge
    always @(negedge line_clk_o) begin
        blk = (pos / BLK) % dsfm_pkg::BLKS_PER_SUB;
        sub = pos / (BLK * dsfm_pkg::BLKS_PER_SUB);
        bit_v = 1'b0;
        if (pos % BLK == 0) begin
            if (blk % 2 == 1) begin
                bit_v = dsfm_pkg::F_PATTERN[3 - blk / 2];
                if (f_bad > 0) begin
                    bit_v = ~bit_v;
                    f_bad--;
                end
            end else if (blk == 0 && sub >= 4) begin
                bit_v = dsfm_pkg::M_PATTERN[6 - sub];
                if (m_bad > 0) begin
                    bit_v = ~bit_v;
                    m_bad--;
                end
            end else if (blk == 0 && sub == 2) begin
                // Payload is all zero, so the good parity bit is 0
                if (p_bad > 0) begin
                    bit_v = 1'b1;
                    p_bad--;
                end
            end
        end
        data_o <= bit_v;
        pos = (pos + 1) % (BLK * 56);
    end
endmodule // dsfm_line_model

// ==== test/dsfm_top_tb.sv ====
// Bench for the frame maintenance block: Wishbone tasks and scenarios.
// Assumes dsfm_pkg, dsfm_top and dsfm_line_model are compiled first.
`timescale 1ns/10ps
module dsfm_top_tb;
    // Short blocks keep the run within budget; frame layout is unchanged
    localparam int BLK = 5;
    localparam int FB = BLK * 25;
    localparam int MF = BLK * 700;
    localparam int ALIGN = 12 * MF;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic sel = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat;
    logic [7:0] q;
    logic ack, loss_of_alignment, irq, line_clk, line_dat;
    int errors = 0;
    int compares = 0;
    always #5 clk = ~clk;
    dsfm_top #(.BLK_BITS(BLK)) u_dut (.CLK_I(clk), .SYS_RST_I(rst),
        .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .DAT_O(rdat),
        .ACK_O(ack), .RX_LINE_CLK_I(line_clk), .RX_DATA_I(line_dat),
        .LOSS_OF_ALIGNMENT_O(loss_of_alignment), .INT_O(irq));
    dsfm_line_model #(.BLK(BLK)) u_line (.line_clk_o(line_clk),
        .data_o(line_dat));
    task automatic test_done();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] d, input logic s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            chk("ack", 8'h01, 8'h00);
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 1'b1);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic wait_oof(input logic v, input int lim);
        int n;
        n = 0;
        while (loss_of_alignment !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("oof_pin", {7'h0, v}, {7'h0, loss_of_alignment});
        if (n >= lim) test_done();
    endtask
    // Waits for injected F- and M-bit errors to go out, then checks the pin stays low
    task automatic steady(input int cycles);
        logic hit;
        int n;
        hit = 1'b0;
        n = 0;
        while ((u_line.f_bad > 0 || u_line.m_bad > 0) && n < 4 * MF) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4 * MF) chk("inject", 8'h00, 8'h01);
        repeat (cycles) begin
            @(posedge clk);
            hit = hit | loss_of_alignment;
        end
        chk("oof_steady", 8'h00, {7'h0, hit});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk("oof_pin", 8'h01, {7'h0, loss_of_alignment});
        rdchk(dsfm_pkg::ADDR_IO_CTRL, dsfm_pkg::IO_CTRL_RESET);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h10);
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h00);
        rdchk(8'h55, 8'h00);
        wb(1'b1, dsfm_pkg::ADDR_RX_CFG, 8'hff, 1'b0);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h10);
        wr(dsfm_pkg::ADDR_RX_CFG, 8'hff);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h1f);
        wr(dsfm_pkg::ADDR_INT_MASK, 8'h00);
        wr(dsfm_pkg::ADDR_IO_CTRL, 8'ha1);
        rdchk(dsfm_pkg::ADDR_IO_CTRL, 8'ha0);
        chk("int_pin", 8'h00, {7'h0, irq});
        wr(dsfm_pkg::ADDR_INT_MASK, 8'h03);
        rdchk(dsfm_pkg::ADDR_INT_MASK, 8'h03);
        chk("int_pin", 8'h01, {7'h0, irq});
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h03);
        @(posedge clk);
        chk("int_pin", 8'h00, {7'h0, irq});
        $display("test registers done");
        wr(dsfm_pkg::ADDR_RX_CFG, 8'h00);
        wr(dsfm_pkg::ADDR_INT_MASK, 8'h01);
        wait_oof(1'b0, ALIGN);
        chk("int_pin", 8'h01, {7'h0, irq});
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h01);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h00);
        u_line.f_bad = 5;
        steady(24 * FB);
        $display("test alignment done");
        wr(dsfm_pkg::ADDR_RX_CFG, 8'h02);
        u_line.m_bad = 4;
        steady(FB * 4);
        u_line.f_bad = 3;
        wait_oof(1'b1, 5 * FB);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h12);
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h01);
        $display("test f-bit loss done");
        wait_oof(1'b0, ALIGN);
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h01);
        wr(dsfm_pkg::ADDR_IO_CTRL, 8'ha1);
        wait_oof(1'b1, 4);
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h03);
        $display("test forced reframe done");
        wait_oof(1'b0, ALIGN);
        rdchk(dsfm_pkg::ADDR_INT_STAT, 8'h01);
        wr(dsfm_pkg::ADDR_RX_CFG, 8'h01);
        u_line.m_bad = 3;
        wait_oof(1'b1, 3 * MF);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h11);
        $display("test m-bit loss done");
        wait_oof(1'b0, ALIGN);
        wr(dsfm_pkg::ADDR_RX_CFG, 8'h04);
        u_line.p_bad = 2;
        wait_oof(1'b1, 4 * MF);
        rdchk(dsfm_pkg::ADDR_RX_CFG, 8'h14);
        $display("test parity loss done");
        test_done();
    end
endmodule // dsfm_top_tb
